/* File: logic/hpb_pkg.sv */
// Purpose: Shared constants and types of the hot-plug bus buffer control.
// Assumes: 50 MHz main clock.
// Notes: Times are kept in their own units; cycle counts derive from them.
package hpb_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int STUCK_MS = 30;
  localparam int RECOV_DLY_US = 40;
  localparam int RECOV_HZ = 8500;
  localparam int RECOV_PULSES = 16;
  // Longest time, rounded down
  localparam int STUCK_CYC_DEF = (CLK_HZ / 1000) * STUCK_MS;
  // Least time, rounded up
  localparam int RECOV_DLY_CYC = ((CLK_HZ / 1000) * RECOV_DLY_US + 999) / 1000;
  localparam int RECOV_HALF_CYC = CLK_HZ / (2 * RECOV_HZ);
  // Backplane idle length in link clock cycles
  localparam int IDLE_CYC_DEF = 128;
  localparam int LOOP_HOLD = 4;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int TMR_W = 22;
  localparam int DLY_W = 13;
  localparam int PLS_W = 5;
  localparam int IDL_W = 16;

  // ----------------------------------------
  // Line and sync vector positions
  // ----------------------------------------
  localparam int L_BD = 0;
  localparam int L_BC = 1;
  localparam int L_CD = 2;
  localparam int L_CC = 3;
  localparam int M_CD = 0;
  localparam int M_CC = 1;
  localparam int M_SUP = 2;
  localparam int M_EN = 3;
  localparam int M_AHI = 4;
  localparam int M_ALO = 5;
  localparam int M_STOP = 6;
  localparam int M_IDLE = 7;
  localparam int M_W = 8;
  localparam int K_CONN = 4;
  localparam int K_CE = 5;
  localparam int K_W = 6;

  // ----------------------------------------
  // Values
  // ----------------------------------------
  localparam logic LINE_LOW = 1'b0;
  localparam logic [3:0] BOOST_NONE = 4'h0;
  localparam logic [3:0] BOOST_ALL = 4'hF;
  localparam logic [3:0] BOOST_CARD = 4'hC;

  typedef enum logic [3:0] {
    ST_LOCK = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_CONN = 4'b0100,
    ST_FAULT = 4'b1000
  } hpb_state_t;
endpackage

/* File: logic/hpb_sync.sv */
// Purpose: Three-flop synchroniser for a vector of independent levels.
// Assumes: Synchronous active-low reset in the receiving clock domain.
// Notes: Output moves only once the second and third flops agree.
`timescale 1ns/1ps
module hpb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Capture chain; first flop feeds only the second
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
    end else if (ce_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a bit once two stages agree
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q_o <= RST;
    end else if (ce_i) begin
      q_o <= (s2_reg & s3_reg) | (q_o & (s2_reg | s3_reg));
    end
  end
endmodule

/* File: logic/hpb_ctrl.sv */
// Purpose: Control of a hot-plug two-wire bus buffer between backplane and card.
// Assumes: Line pins are sampled through synchronisers; the link clock is free running.
// Notes: Link logic on lclk_i handles line drive and stop/idle detect.
//
// Contract
// - Enable low isolates segments, holds connected low, pauses recovery clocks.
// - Enable rising after stuck fault forces connection without idle or stop.
// - Accel high disables all boosters, low enables all, float card only.
// - Below supply lockout, ignore all lines and stay disconnected.
// - After lockout, wait backplane stop or idle and card high, then connect.
// - While connected, a low on either side shows on both sides.
// - Stuck timer runs while a card line is low, clears when both high.
// - Timer limit breaks connection and drives fault flag low.
// - After the delay, up to sixteen recovery clocks on card clock.
// - Card lines high after fault release flag; reconnect by start-up rules.
// - Powering up stuck never connects; fault and recovery follow timeout.
// - Connected flag is high only while the connection is active.
// - Enable high waits for backplane stop or idle and card lines high before connecting.
// - Forced connection clears stuck timer but keeps it running.
// - Boosters stay off during recovery clocking.
`timescale 1ns/1ps
module hpb_ctrl
  import hpb_pkg::*;
#(
  parameter int STUCK_CYC = hpb_pkg::STUCK_CYC_DEF,
  parameter int IDLE_CYC = hpb_pkg::IDLE_CYC_DEF
) (
  // Main clock, reset, enable
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  // Link clock
  input wire logic lclk_i,
  // Control pins
  input wire logic supply_ok_i,
  input wire logic enable_i,
  input wire logic acc_hi_i,
  input wire logic acc_lo_i,
  // Backplane lines
  input wire logic backplane_data_line_i,
  output logic backplane_data_line_o,
  output logic backplane_data_line_oe_o,
  input wire logic backplane_clock_line_i,
  output logic backplane_clock_line_o,
  output logic backplane_clock_line_oe_o,
  // Card lines
  input wire logic card_data_line_i,
  output logic card_data_line_o,
  output logic card_data_line_oe_o,
  input wire logic card_clock_line_i,
  output logic card_clock_line_o,
  output logic card_clock_line_oe_o,
  // Status
  output logic ready_o,
  output logic fault_n_o,
  output logic [3:0] boost_o
);
  import hpb_pkg::*;

  // ----------------------------------------
  // Main domain declarations
  // ----------------------------------------
  logic [M_W-1:0] ms;
  hpb_state_t state_reg;
  hpb_state_t state_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [DLY_W-1:0] rdly_reg;
  logic [DLY_W-1:0] half_reg;
  logic [PLS_W-1:0] pls_reg;
  logic rclk_low_reg;
  logic en_prev_reg;
  logic stop_prev_reg;
  logic stop_seen_reg;
  logic fault_seen_reg;
  logic conn_reg;
  logic ready_reg;
  logic fault_reg;
  logic [3:0] boost_reg;
  logic card_high;
  logic en_rise;
  logic stop_evt;
  logic stuck_hit;
  logic force_conn;
  logic recov_act;

  // ----------------------------------------
  // Link domain declarations
  // ----------------------------------------
  logic lrs1_reg;
  logic lrs2_reg;
  logic [K_W-1:0] ks;
  logic lce;
  logic bd_prev_reg;
  logic stop_tgl_reg;
  logic [IDL_W-1:0] idle_cnt_reg;
  logic bp_idle_reg;
  logic [3:0] drv_reg;

  // ----------------------------------------
  // Main domain input sampling
  // ----------------------------------------
  hpb_sync #(.W(M_W), .RST(8'h03)) u_msync (
    .clk_i(mclk_i),
    .rst_n_i(nrst_i),
    .ce_i(ce_i),
    .d_i({bp_idle_reg, stop_tgl_reg, acc_lo_i, acc_hi_i, enable_i, supply_ok_i,
          card_clock_line_i, card_data_line_i}),
    .q_o(ms)
  );

  // Decoded conditions
  assign card_high = ms[M_CD] & ms[M_CC];
  assign en_rise = ms[M_EN] & ~en_prev_reg;
  assign stop_evt = ms[M_STOP] ^ stop_prev_reg;
  assign stuck_hit = ~card_high & (tmr_reg == TMR_W'(STUCK_CYC - 1));
  assign force_conn = en_rise & fault_seen_reg;
  assign recov_act = (state_reg == ST_FAULT) & (rdly_reg == DLY_W'(RECOV_DLY_CYC));

  // Edge history of enable and stop toggle
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      en_prev_reg <= 1'b0;
      stop_prev_reg <= 1'b0;
    end else if (ce_i) begin
      en_prev_reg <= ms[M_EN];
      stop_prev_reg <= ms[M_STOP];
    end
  end

  // ----------------------------------------
  // Connection state machine
  // ----------------------------------------
  // Next state selection
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCK: begin
        if (ms[M_SUP]) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (force_conn) begin
          state_next = ST_CONN;
        end else if (stuck_hit) begin
          state_next = ST_FAULT;
        end else if (ms[M_EN] & (stop_seen_reg | ms[M_IDLE]) & card_high) begin
          state_next = ST_CONN;
        end
      end
      ST_CONN: begin
        if (!ms[M_EN]) begin
          state_next = ST_WAIT;
        end else if (stuck_hit) begin
          state_next = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (force_conn) begin
          state_next = ST_CONN;
        end else if (card_high & ~rclk_low_reg) begin
          state_next = ST_WAIT;
        end
      end
      default: begin
        state_next = ST_LOCK;
      end
    endcase
    if (!ms[M_SUP]) begin
      state_next = ST_LOCK;
    end
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state_reg <= ST_LOCK;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // Stop seen since entering the wait state
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      stop_seen_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_reg != ST_WAIT) begin
        stop_seen_reg <= 1'b0;
      end else if (stop_evt) begin
        stop_seen_reg <= 1'b1;
      end
    end
  end

  // Fault history, allowing a forced reconnect
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      fault_seen_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_next == ST_FAULT) begin
        fault_seen_reg <= 1'b1;
      end else if (force_conn || state_reg == ST_LOCK) begin
        fault_seen_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Stuck-low timer
  // ----------------------------------------
  // Counts while a card line is low, saturates at the limit
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      tmr_reg <= '0;
    end else if (ce_i) begin
      if (state_reg == ST_LOCK || card_high) begin
        tmr_reg <= '0;
      end else if (force_conn) begin
        tmr_reg <= '0;
      end else if (tmr_reg != TMR_W'(STUCK_CYC)) begin
        tmr_reg <= tmr_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Recovery clocking
  // ----------------------------------------
  // Delay, then half-period toggles of the card clock drive
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdly_reg <= '0;
      half_reg <= '0;
      pls_reg <= '0;
      rclk_low_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_reg != ST_FAULT) begin
        rdly_reg <= '0;
        half_reg <= '0;
        pls_reg <= '0;
        rclk_low_reg <= 1'b0;
      end else if (!ms[M_EN]) begin
        rclk_low_reg <= 1'b0;
      end else if (!recov_act) begin
        rdly_reg <= rdly_reg + 1'b1;
      end else if (pls_reg != PLS_W'(RECOV_PULSES)) begin
        if (half_reg == DLY_W'(RECOV_HALF_CYC - 1)) begin
          half_reg <= '0;
          rclk_low_reg <= ~rclk_low_reg;
          if (rclk_low_reg) begin
            pls_reg <= pls_reg + 1'b1;
          end
        end else begin
          half_reg <= half_reg + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Connected and fault flags follow the next state
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      conn_reg <= 1'b0;
      ready_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (ce_i) begin
      conn_reg <= state_next == ST_CONN;
      ready_reg <= state_next == ST_CONN;
      fault_reg <= state_next == ST_FAULT;
    end
  end

  // Booster selection from the three-state accelerator control
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      boost_reg <= BOOST_NONE;
    end else if (ce_i) begin
      if (state_next != ST_CONN || recov_act) begin
        boost_reg <= BOOST_NONE;
      end else if (ms[M_AHI]) begin
        boost_reg <= BOOST_NONE;
      end else if (ms[M_ALO]) begin
        boost_reg <= BOOST_ALL;
      end else begin
        boost_reg <= BOOST_CARD;
      end
    end
  end

  assign ready_o = ready_reg;
  assign fault_n_o = ~fault_reg;
  assign boost_o = boost_reg;

  // ----------------------------------------
  // Link domain reset and sampling
  // ----------------------------------------
  // Reset carried into the link clock
  always_ff @(posedge lclk_i) begin
    lrs1_reg <= nrst_i;
    lrs2_reg <= lrs1_reg;
  end

  // Synchronisers run free so the enable itself can cross
  hpb_sync #(.W(K_W), .RST(6'h0F)) u_lsync (
    .clk_i(lclk_i),
    .rst_n_i(lrs2_reg),
    .ce_i(1'b1),
    .d_i({ce_i, conn_reg, card_clock_line_i, card_data_line_i,
          backplane_clock_line_i, backplane_data_line_i}),
    .q_o(ks)
  );

  assign lce = ks[K_CE];

  // ----------------------------------------
  // Stop and idle detection
  // ----------------------------------------
  // Stop toggles an event flag; idle is a level
  always_ff @(posedge lclk_i) begin
    if (!lrs2_reg) begin
      bd_prev_reg <= 1'b1;
      stop_tgl_reg <= 1'b0;
      idle_cnt_reg <= '0;
      bp_idle_reg <= 1'b0;
    end else if (lce) begin
      bd_prev_reg <= ks[L_BD];
      if (ks[L_BD] & ~bd_prev_reg & ks[L_BC]) begin
        stop_tgl_reg <= ~stop_tgl_reg;
      end
      if (!(ks[L_BD] & ks[L_BC])) begin
        idle_cnt_reg <= '0;
        bp_idle_reg <= 1'b0;
      end else if (idle_cnt_reg == IDL_W'(IDLE_CYC - 1)) begin
        bp_idle_reg <= 1'b1;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Line pair drive
  // ----------------------------------------
  // Each pair copies a low from one side to the other; a side that we
  // drive is blocked from echoing back until the sampled level settles.
  for (genvar p = 0; p < 2; p++) begin : g_pair
    logic [LOOP_HOLD-1:0] bp_hist_reg;
    logic [LOOP_HOLD-1:0] cd_hist_reg;
    always_ff @(posedge lclk_i) begin
      if (!lrs2_reg) begin
        drv_reg[p] <= 1'b0;
        drv_reg[p + 2] <= 1'b0;
        bp_hist_reg <= '0;
        cd_hist_reg <= '0;
      end else if (lce) begin
        drv_reg[p + 2] <= ks[K_CONN] & ~ks[p] & ~drv_reg[p] & ~(|bp_hist_reg);
        drv_reg[p] <= ks[K_CONN] & ~ks[p + 2] & ~drv_reg[p + 2] & ~(|cd_hist_reg);
        bp_hist_reg <= {bp_hist_reg[LOOP_HOLD-2:0], drv_reg[p]};
        cd_hist_reg <= {cd_hist_reg[LOOP_HOLD-2:0], drv_reg[p + 2]};
      end
    end
  end

  assign backplane_data_line_o = LINE_LOW;
  assign backplane_clock_line_o = LINE_LOW;
  assign card_data_line_o = LINE_LOW;
  assign card_clock_line_o = LINE_LOW;
  assign backplane_data_line_oe_o = drv_reg[L_BD];
  assign backplane_clock_line_oe_o = drv_reg[L_BC];
  assign card_data_line_oe_o = drv_reg[L_CD];
  // Recovery pulses share the card clock pin
  assign card_clock_line_oe_o = drv_reg[L_CC] | rclk_low_reg;
endmodule

/* File: tb/hpb_bus_model.sv */
// Purpose: Far-side bus parties on backplane and card, as open-drain wires.
// Assumes: Every line has a pull-up, so a released line reads high.
// Notes: Bit order follows the line positions of the package.
`timescale 1ns/1ps
module hpb_bus_model (
  // Far-side parties pulling low
  input wire logic [3:0] pull_i,
  // Device drive enables and the levels it drives
  input wire logic [3:0] oe_i,
  input wire logic [3:0] val_i,
  // Resolved levels
  output logic [3:0] line_o
);
  // Wired-AND: any low driver wins, all released gives the pull-up level
  assign line_o = ~pull_i & ~(oe_i & ~val_i);
endmodule

/* File: tb/hpb_ctrl_checker.sv */
// Purpose: Port-level assertions for the buffer control.
// Assumes: Lines seen through the device's synchronisers, a few cycles late.
// Notes: The stuck-low helper counter follows the raw card lines, so it leads the device.
`timescale 1ns/1ps
module hpb_ctrl_checker
  import hpb_pkg::*;
#(
  parameter int STUCK_CYC = 200
) (
  // Clock and control
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic supply_ok_i,
  input wire logic enable_i,
  input wire logic acc_hi_i,
  input wire logic acc_lo_i,
  // Lines
  input wire logic card_data_line_i,
  input wire logic card_clock_line_i,
  input wire logic backplane_data_line_oe_o,
  input wire logic card_data_line_oe_o,
  input wire logic card_clock_line_oe_o,
  // Status
  input wire logic ready_o,
  input wire logic fault_n_o,
  input wire logic [3:0] boost_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [3:0] exp_b;
  int stk_cnt;
  int flt_cnt;
  int pls_cnt;
  // Booster pattern due for the accelerator pins
  assign exp_b = acc_hi_i ? BOOST_NONE : (acc_lo_i ? BOOST_ALL : BOOST_CARD);
  // Stuck-low time as seen at the card pins
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || !supply_ok_i || (card_data_line_i && card_clock_line_i)) begin
      stk_cnt <= 0;
    end else if ($rose(enable_i) && !fault_n_o) begin
      stk_cnt <= 0;
    end else if (ce_i) begin
      stk_cnt <= stk_cnt + 1;
    end
  end
  // Time in fault and recovery pulses issued
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || fault_n_o) begin
      flt_cnt <= 0;
      pls_cnt <= 0;
    end else begin
      flt_cnt <= flt_cnt + 1;
      if ($rose(card_clock_line_oe_o)) begin
        pls_cnt <= pls_cnt + 1;
      end
    end
  end
  sequence s_acc_steady;
    (ready_o && $stable(exp_b))[*6];
  endsequence
  a_lock_quiet: assert property ((!supply_ok_i)[*6] |->
    !ready_o && !card_data_line_oe_o && !backplane_data_line_oe_o)
    else $error("activity during lockout");
  a_en_isolate: assert property ((!enable_i)[*6] |->
    !ready_o && !$rose(card_clock_line_oe_o)) else $error("enable low not isolating");
  a_acc_boost: assert property (s_acc_steady |-> boost_o == exp_b)
    else $error("booster pattern wrong");
  a_boost_conn: assert property (boost_o != BOOST_NONE |-> ready_o)
    else $error("boosters on while unconnected");
  a_recov_quiet: assert property (!fault_n_o && card_clock_line_oe_o |->
    boost_o == BOOST_NONE) else $error("boosters on during recovery");
  a_fault_early: assert property ($fell(fault_n_o) |-> stk_cnt >= STUCK_CYC - 1)
    else $error("fault before timeout");
  a_fault_late: assert property (stk_cnt == STUCK_CYC + 8 |-> !fault_n_o)
    else $error("no fault after timeout");
  a_fault_break: assert property ($fell(fault_n_o) |=> (!ready_o)[*3])
    else $error("connection kept on fault");
  a_recov_delay: assert property ($rose(card_clock_line_oe_o) && !fault_n_o |->
    flt_cnt >= RECOV_DLY_CYC - 1) else $error("recovery clock too early");
  a_recov_count: assert property (pls_cnt <= RECOV_PULSES)
    else $error("too many recovery pulses");
endmodule

bind hpb_ctrl hpb_ctrl_checker #(.STUCK_CYC(STUCK_CYC)) hpb_ctrl_checker_i (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .ce_i(ce_i), .supply_ok_i(supply_ok_i),
  .enable_i(enable_i), .acc_hi_i(acc_hi_i), .acc_lo_i(acc_lo_i),
  .card_data_line_i(card_data_line_i), .card_clock_line_i(card_clock_line_i),
  .backplane_data_line_oe_o(backplane_data_line_oe_o),
  .card_data_line_oe_o(card_data_line_oe_o), .card_clock_line_oe_o(card_clock_line_oe_o),
  .ready_o(ready_o), .fault_n_o(fault_n_o), .boost_o(boost_o));

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the buffer control.
// Assumes: Shortened stuck timeout and idle length.
// Notes: Recovery is checked over its first low phase only, to keep the run short.
`timescale 1ns/1ps
module tb;
  import hpb_pkg::*;
  localparam int STK = 200;
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic sup = 1'b0;
  logic en = 1'b1;
  logic ahi = 1'b1;
  logic alo = 1'b0;
  logic [3:0] pull = 4'h0;
  wire [3:0] oe;
  wire [3:0] dv;
  wire [3:0] ln;
  logic ready;
  logic fault_n;
  logic [3:0] boost;
  int n_fail = 0;
  int compares = 0;
  // ----------------------------------------
  // Clocks and parts
  // ----------------------------------------
  initial begin
    forever #10 mclk = ~mclk;
  end
  initial begin
    #3;
    forever #6 lclk = ~lclk;
  end
  hpb_ctrl #(.STUCK_CYC(STK), .IDLE_CYC(16)) hpb_ctrl_i (
    .mclk_i(mclk), .nrst_i(nrst), .ce_i(1'b1), .lclk_i(lclk),
    .supply_ok_i(sup), .enable_i(en), .acc_hi_i(ahi), .acc_lo_i(alo),
    .backplane_data_line_i(ln[L_BD]), .backplane_data_line_o(dv[L_BD]),
    .backplane_data_line_oe_o(oe[L_BD]),
    .backplane_clock_line_i(ln[L_BC]), .backplane_clock_line_o(dv[L_BC]),
    .backplane_clock_line_oe_o(oe[L_BC]),
    .card_data_line_i(ln[L_CD]), .card_data_line_o(dv[L_CD]),
    .card_data_line_oe_o(oe[L_CD]),
    .card_clock_line_i(ln[L_CC]), .card_clock_line_o(dv[L_CC]),
    .card_clock_line_oe_o(oe[L_CC]),
    .ready_o(ready), .fault_n_o(fault_n), .boost_o(boost));
  hpb_bus_model hpb_bus_model_i (.pull_i(pull), .oe_i(oe), .val_i(dv), .line_o(ln));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    while (ready !== 1'b1 && i < 400) begin
      cyc(1);
      i++;
    end
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_start();
    pull <= 4'h1;
    cyc(100);
    chk(ready, 4'h0);
    sup <= 1'b1;
    cyc(100);
    chk(ready, 4'h0);
    pull <= 4'h0;
    wait_rdy();
    chk(ready, 4'h1);
    chk(fault_n, 4'h1);
    $display("test start done");
  endtask
  task automatic t_acc();
    logic [1:0] pins [4] = '{2'b11, 2'b10, 2'b01, 2'b00};
    logic [3:0] exp [4] = '{BOOST_NONE, BOOST_NONE, BOOST_ALL, BOOST_CARD};
    for (int i = 0; i < 4; i++) begin
      {ahi, alo} <= pins[i];
      cyc(10);
      chk(boost, exp[i]);
    end
    $display("test acc done");
  endtask
  task automatic t_pass();
    int a [2] = '{L_BD, L_CC};
    int b [2] = '{L_CD, L_BC};
    for (int i = 0; i < 2; i++) begin
      pull[a[i]] <= 1'b1;
      cyc(4);
      chk(oe[b[i]], 4'h1);
      chk(ln[b[i]], 4'h0);
      pull[a[i]] <= 1'b0;
      cyc(4);
      chk(ln[b[i]], 4'h1);
    end
    chk(ready, 4'h1);
    $display("test pass done");
  endtask
  task automatic t_enable();
    en <= 1'b0;
    cyc(8);
    chk(ready, 4'h0);
    en <= 1'b1;
    wait_rdy();
    chk(ready, 4'h1);
    $display("test enable done");
  endtask
  task automatic t_stuck();
    int i;
    pull[L_CD] <= 1'b1;
    cyc(STK + 10);
    chk(fault_n, 4'h0);
    chk(ready, 4'h0);
    cyc(RECOV_DLY_CYC - 20);
    chk(oe[L_CC], 4'h0);
    i = 0;
    // First low phase starts one half period after the delay
    while (oe[L_CC] !== 1'b1 && i < RECOV_HALF_CYC + 40) begin
      cyc(1);
      i++;
    end
    chk(oe[L_CC], 4'h1);
    chk(boost, BOOST_NONE);
    cyc(RECOV_HALF_CYC - 4);
    chk(oe[L_CC], 4'h1);
    cyc(8);
    chk(oe[L_CC], 4'h0);
    en <= 1'b0;
    cyc(50);
    en <= 1'b1;
    cyc(10);
    chk(ready, 4'h1);
    cyc(STK + 10);
    chk(fault_n, 4'h0);
    pull[L_CD] <= 1'b0;
    cyc(10);
    chk(fault_n, 4'h1);
    wait_rdy();
    chk(ready, 4'h1);
    $display("test stuck done");
  endtask
  task automatic t_pwr();
    sup <= 1'b0;
    pull[L_CC] <= 1'b1;
    cyc(20);
    sup <= 1'b1;
    cyc(60);
    chk(ready, 4'h0);
    cyc(STK);
    chk(fault_n, 4'h0);
    pull[L_CC] <= 1'b0;
    cyc(10);
    chk(fault_n, 4'h1);
    wait_rdy();
    chk(ready, 4'h1);
    $display("test power done");
  endtask
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    cyc(12);
    nrst <= 1'b1;
    t_start();
    t_acc();
    t_pass();
    t_enable();
    t_stuck();
    t_pwr();
    results();
  end
  initial begin
    cyc(20000);
    n_fail++;
    results();
  end
endmodule
